/* logic/timer16_regs.svh */
// Register offsets, field positions and reset values of the 16-bit timer core.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// =============================================================
// Register byte offsets
`define TMR_OFS_CONTROL      12'h000
`define TMR_OFS_COUNT        12'h004
`define TMR_OFS_PRE_LIMIT    12'h008
`define TMR_OFS_PRE_COUNT    12'h00c
`define TMR_OFS_SOURCE       12'h010
`define TMR_OFS_MATCH_CTRL   12'h014
`define TMR_OFS_MATCH_VALUE  12'h018
`define TMR_OFS_IRQ_MODE     12'h01c

// =============================================================
// Field positions
`define TMR_BIT_ENABLE       0
`define TMR_BIT_RESET_REQ    1
`define TMR_SOURCE_MODE_LSB  0
`define TMR_INPUT_SEL_LSB    2
`define TMR_BIT_MATCH_IE     0
`define TMR_BIT_MATCH_RST    1
`define TMR_BIT_MATCH_STOP   2
`define TMR_IRQ_MODE_LSB     0

// =============================================================
// Reset values and codes
`define TMR_RST_COUNT        16'h0000
`define TMR_RST_PRE          8'h00
`define TMR_RST_MODE         2'h0
`define TMR_RST_IRQ_MODE     3'h0
`define TMR_INPUT_CAP_ZERO   2'h0
`define TMR_IRQ_PULSE        3'h0

`endif

/* logic/timer16_pkg.sv */
// Types shared by the 16-bit timer core.
// Assumes the register header supplies all numeric constants.
`default_nettype none

package timer16_pkg;

    // Count source, in the order of its two-bit field code.
    typedef enum logic [1:0] {
        SRC_TIMER,
        SRC_RISE,
        SRC_FALL,
        SRC_BOTH
    } count_source_e;

endpackage : timer16_pkg

`default_nettype wire

/* logic/timer16_prescale_match_core.sv */
// 16-bit timer/counter with 8-bit prescaler and one match channel, APB slave.
// Assumes one clock, a synchronous active-low reset and a capture input
// that is already synchronous to clock_i.
//
// Summary of operation
// - Counter reset clears both counts next edge.
// - Counter reset bit self-clears after reset.
// - Counts advance only while count enable set.
// - Always edge-aligned up counting.
// - Timer count steps at prescale terminal value.
// - Timer count wraps silently to zero.
// - Prescale count steps, returns zero at limit.
// - Timer steps every limit plus one clocks.
// - Capture input sampled, consecutive samples classify edge.
// - Counter mode counts only selected edge.
// - Mode field: timer, rise, fall, both.
// - Input select zero picks capture input zero.
// - Match stop halts counts, clears enable.
// - Match reset returns timer count to zero.
// - Stop wins when stop and reset both set.
// - Match raises interrupt when enabled.
// - Interrupt appears clock after first match.
// - Match reset at end of timer cycle.
// - Enable clears clock after match reached.
`include "timer16_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module timer16_prescale_match_core #(
    parameter int CNT_WIDTH = 16,
    parameter int PRE_WIDTH = 8
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        capture_input_zero_i,
    output var  logic        match_irq_o
);

    // =============================================================
    // Register state

    logic                 count_enable_reg;
    logic                 count_enable_next;
    logic                 counter_reset_request_reg;
    logic                 counter_reset_request_next;
    logic [CNT_WIDTH-1:0] timer_count_reg;
    logic [CNT_WIDTH-1:0] timer_count_next;
    logic [PRE_WIDTH-1:0] prescale_count_reg;
    logic [PRE_WIDTH-1:0] prescale_count_next;
    logic [PRE_WIDTH-1:0] divider_limit_value_reg;
    logic [1:0]           count_source_mode_reg;
    logic [1:0]           count_input_select_reg;
    logic                 match_zero_stop_reg;
    logic                 match_zero_reset_reg;
    logic                 match_zero_irq_enable_reg;
    logic [CNT_WIDTH-1:0] match_value_zero_reg;
    logic [2:0]           interrupt_condition_mode_reg;
    logic                 cap_sample_reg;
    logic                 cap_prior_reg;
    logic                 match_seen_reg;
    logic                 match_irq_next;

    // =============================================================
    // Bus decode

    wire logic bus_setup = psel_i && !penable_i;
    wire logic bus_write = psel_i && penable_i && pwrite_i;

    wire logic sel_control = (paddr_i == `TMR_OFS_CONTROL);
    wire logic sel_count   = (paddr_i == `TMR_OFS_COUNT);
    wire logic sel_limit   = (paddr_i == `TMR_OFS_PRE_LIMIT);
    wire logic sel_pcount  = (paddr_i == `TMR_OFS_PRE_COUNT);
    wire logic sel_source  = (paddr_i == `TMR_OFS_SOURCE);
    wire logic sel_mctrl   = (paddr_i == `TMR_OFS_MATCH_CTRL);
    wire logic sel_mvalue  = (paddr_i == `TMR_OFS_MATCH_VALUE);
    wire logic sel_irqmode = (paddr_i == `TMR_OFS_IRQ_MODE);

    wire logic addr_mapped = sel_control || sel_count || sel_limit || sel_pcount
                          || sel_source || sel_mctrl || sel_mvalue || sel_irqmode;

    wire logic wr_control = bus_write && sel_control;
    wire logic wr_count   = bus_write && sel_count;
    wire logic wr_limit   = bus_write && sel_limit;
    wire logic wr_pcount  = bus_write && sel_pcount;
    wire logic wr_source  = bus_write && sel_source;
    wire logic wr_mctrl   = bus_write && sel_mctrl;
    wire logic wr_mvalue  = bus_write && sel_mvalue;
    wire logic wr_irqmode = bus_write && sel_irqmode;

    // Unmapped addresses answer with an error; writes to them are dropped.
    // Every access completes in its first access cycle.
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_mapped;

    // =============================================================
    // Read data

    wire logic [31:0] rd_control = {30'h0, counter_reset_request_reg, count_enable_reg};
    wire logic [31:0] rd_count   = {{(32-CNT_WIDTH){1'b0}}, timer_count_reg};
    wire logic [31:0] rd_limit   = {{(32-PRE_WIDTH){1'b0}}, divider_limit_value_reg};
    wire logic [31:0] rd_pcount  = {{(32-PRE_WIDTH){1'b0}}, prescale_count_reg};
    wire logic [31:0] rd_source  = {28'h0, count_input_select_reg, count_source_mode_reg};
    wire logic [31:0] rd_mctrl   = {29'h0, match_zero_stop_reg, match_zero_reset_reg,
                                    match_zero_irq_enable_reg};
    wire logic [31:0] rd_mvalue  = {{(32-CNT_WIDTH){1'b0}}, match_value_zero_reg};
    wire logic [31:0] rd_irqmode = {29'h0, interrupt_condition_mode_reg};

    wire logic [31:0] rd_word =
        sel_control ? rd_control :
        sel_count   ? rd_count   :
        sel_limit   ? rd_limit   :
        sel_pcount  ? rd_pcount  :
        sel_source  ? rd_source  :
        sel_mctrl   ? rd_mctrl   :
        sel_mvalue  ? rd_mvalue  :
        sel_irqmode ? rd_irqmode : 32'h0000_0000;

    // Read data is captured in the setup cycle and held through the access.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            prdata_o <= 32'h0000_0000;
        else if (bus_setup && !pwrite_i)
            prdata_o <= rd_word;
    end

    // =============================================================
    // Count source and edge classification

    // Two consecutive samples of the selected input are compared.
    wire logic cap_selected = (count_input_select_reg == `TMR_INPUT_CAP_ZERO)
                            && capture_input_zero_i;
    wire logic edge_rise = cap_sample_reg && !cap_prior_reg;
    wire logic edge_fall = !cap_sample_reg && cap_prior_reg;

    timer16_pkg::count_source_e source_mode;
    assign source_mode = timer16_pkg::count_source_e'(count_source_mode_reg);

    logic count_step;
    always_comb
    begin
        unique case (source_mode)
            timer16_pkg::SRC_TIMER: count_step = 1'b1;
            timer16_pkg::SRC_RISE:  count_step = edge_rise;
            timer16_pkg::SRC_FALL:  count_step = edge_fall;
            timer16_pkg::SRC_BOTH:  count_step = edge_rise || edge_fall;
        endcase
    end

    // Both samples reset low, the idle level of the input, so no false
    // edge is seen right after reset.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            cap_sample_reg <= 1'b0;
            cap_prior_reg  <= 1'b0;
        end
        else
        begin
            cap_sample_reg <= cap_selected;
            cap_prior_reg  <= cap_sample_reg;
        end
    end

    // =============================================================
    // Match detection

    // The first-match flag follows the compare itself, so a software write
    // of the count that lands on the match value is a first match too.
    wire logic match_equal = (timer_count_reg == match_value_zero_reg);
    wire logic match_first = match_equal && !match_seen_reg;

    // A stop takes effect on the clock after the timer reaches the value.
    wire logic stop_hit  = match_first && match_zero_stop_reg && count_enable_reg;
    wire logic counting  = count_enable_reg && !counter_reset_request_reg && !stop_hit;
    wire logic pre_step  = counting && count_step;
    wire logic pre_term  = (prescale_count_reg == divider_limit_value_reg);
    wire logic tc_step   = pre_step && pre_term;
    // Stop has priority, so reset only applies when stop is clear.
    wire logic reset_hit = match_equal && match_zero_reset_reg && !match_zero_stop_reg;

    // =============================================================
    // Count and control next values

    always_comb
    begin
        prescale_count_next = prescale_count_reg;
        timer_count_next    = timer_count_reg;
        if (counter_reset_request_reg)
        begin
            prescale_count_next = `TMR_RST_PRE;
            timer_count_next    = `TMR_RST_COUNT;
        end
        else
        begin
            if (wr_pcount)
                prescale_count_next = pwdata_i[PRE_WIDTH-1:0];
            else if (pre_step && pre_term)
                prescale_count_next = `TMR_RST_PRE;
            else if (pre_step)
                prescale_count_next = prescale_count_reg + 1'b1;
            if (wr_count)
                timer_count_next = pwdata_i[CNT_WIDTH-1:0];
            else if (tc_step && reset_hit)
                timer_count_next = `TMR_RST_COUNT;
            else if (tc_step)
                // Up only; the natural width wrap raises nothing.
                timer_count_next = timer_count_reg + 1'b1;
        end
    end

    always_comb
    begin
        count_enable_next          = count_enable_reg;
        counter_reset_request_next = counter_reset_request_reg;
        if (stop_hit)
            count_enable_next = 1'b0;
        if (counter_reset_request_reg)
            counter_reset_request_next = 1'b0;
        // A software write in the same cycle wins over the hardware clear.
        if (wr_control)
        begin
            count_enable_next = pwdata_i[`TMR_BIT_ENABLE];
            if (pwdata_i[`TMR_BIT_RESET_REQ])
                counter_reset_request_next = 1'b1;
        end
    end

    // Pulse mode gives one cycle per first match; other codes hold a level.
    always_comb
    begin
        if (!match_zero_irq_enable_reg)
            match_irq_next = 1'b0;
        else if (interrupt_condition_mode_reg == `TMR_IRQ_PULSE)
            match_irq_next = match_first;
        else
            match_irq_next = match_equal;
    end

    // =============================================================
    // Clocked state

    // Each register has its own short process; all share the synchronous reset.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            count_enable_reg <= 1'b0;
        else
            count_enable_reg <= count_enable_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            counter_reset_request_reg <= 1'b0;
        else
            counter_reset_request_reg <= counter_reset_request_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            timer_count_reg <= `TMR_RST_COUNT;
        else
            timer_count_reg <= timer_count_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            prescale_count_reg <= `TMR_RST_PRE;
        else
            prescale_count_reg <= prescale_count_next;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_seen_reg <= 1'b0;
        else
            match_seen_reg <= match_equal;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_irq_o <= 1'b0;
        else
            match_irq_o <= match_irq_next;
    end

    // =============================================================
    // Configuration registers

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            divider_limit_value_reg <= `TMR_RST_PRE;
        else if (wr_limit)
            divider_limit_value_reg <= pwdata_i[PRE_WIDTH-1:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            count_source_mode_reg <= `TMR_RST_MODE;
        else if (wr_source)
            count_source_mode_reg <= pwdata_i[`TMR_SOURCE_MODE_LSB +: 2];
    end

    // Reserved select codes are stored; they simply never match an input.
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            count_input_select_reg <= `TMR_INPUT_CAP_ZERO;
        else if (wr_source)
            count_input_select_reg <= pwdata_i[`TMR_INPUT_SEL_LSB +: 2];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_zero_stop_reg <= 1'b0;
        else if (wr_mctrl)
            match_zero_stop_reg <= pwdata_i[`TMR_BIT_MATCH_STOP];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_zero_reset_reg <= 1'b0;
        else if (wr_mctrl)
            match_zero_reset_reg <= pwdata_i[`TMR_BIT_MATCH_RST];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_zero_irq_enable_reg <= 1'b0;
        else if (wr_mctrl)
            match_zero_irq_enable_reg <= pwdata_i[`TMR_BIT_MATCH_IE];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            match_value_zero_reg <= `TMR_RST_COUNT;
        else if (wr_mvalue)
            match_value_zero_reg <= pwdata_i[CNT_WIDTH-1:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            interrupt_condition_mode_reg <= `TMR_RST_IRQ_MODE;
        else if (wr_irqmode)
            interrupt_condition_mode_reg <= pwdata_i[`TMR_IRQ_MODE_LSB +: 3];
    end

endmodule : timer16_prescale_match_core

`default_nettype wire

/* verification/timer16_prescale_match_core_assertions.sv */
// Port-level checker for the 16-bit timer core.
// Assumes binding to the core; APB writes are shadowed for the irq fields.
`timescale 1ns/100ps
`default_nettype none

module timer16_core_checker (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        capture_input_zero_i,
    input wire logic        match_irq_o
);
    // ==========
    // Shadow state
    logic        ie_reg;
    logic [2:0]  mode_reg;
    logic [31:0] mask_reg;
    wire logic   wr_w = psel_i && penable_i && pwrite_i;
    wire logic   rd_w = psel_i && !penable_i && !pwrite_i;

    function automatic logic [31:0] mask_f(input logic [11:0] a);
        case (a)
            12'h000: return 32'h3;
            12'h004, 12'h018: return 32'hffff;
            12'h008, 12'h00c: return 32'hff;
            12'h010: return 32'hf;
            12'h014, 12'h01c: return 32'h7;
            default: return 32'h0;
        endcase
    endfunction : mask_f

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            ie_reg   <= 1'b0;
            mode_reg <= 3'h0;
            mask_reg <= 32'h0;
        end
        else
        begin
            if (wr_w && paddr_i == 12'h014)
                ie_reg <= pwdata_i[0];
            if (wr_w && paddr_i == 12'h01c)
                mode_reg <= pwdata_i[2:0];
            if (rd_w)
                mask_reg <= mask_f(paddr_i);
        end
    end

    // ==========
    // Properties
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_reset_quiet: assert property ($rose(rst_n_i) |-> !match_irq_o && prdata_o == 32'h0)
        else $error("outputs not idle after reset");
    a_irq_gated: assert property (match_irq_o |-> $past(ie_reg))
        else $error("irq without match enable");
    a_irq_pulse: assert property (match_irq_o && mode_reg == 3'h0
        && $past(mode_reg) == 3'h0 |=> !match_irq_o)
        else $error("pulse irq longer than one cycle");
    a_counter_reset_request_clear: assert property (wr_w && paddr_i == 12'h000 && pwdata_i[1]
        ##2 rd_w && paddr_i == 12'h000 |=> !prdata_o[1])
        else $error("counter reset bit not cleared");
    a_read_width: assert property ($past(rd_w) |-> (prdata_o & ~mask_reg) == 32'h0)
        else $error("reserved read bits not zero");
    a_ready_high: assert property (pready_o)
        else $error("ready low");
    a_err_decode: assert property (psel_i && penable_i
        |-> pslverr_o == (mask_f(paddr_i) == 32'h0))
        else $error("slave error does not follow decode");
    a_err_idle: assert property (!(psel_i && penable_i) |-> !pslverr_o)
        else $error("slave error outside access");

    cover property (match_irq_o ##1 match_irq_o);
    cover property (wr_w && pslverr_o);
    cover property (match_irq_o && mode_reg == 3'h0);
endmodule : timer16_core_checker

`default_nettype wire

/* verification/capture_edge_source.sv */
// Model of an external edge source on the capture input.
// Assumes start_i is a one-cycle strobe and half_i is at least one.
`timescale 1ns/100ps
`default_nettype none

module capture_edge_source (
    input  wire logic       clock_i,
    input  wire logic       start_i,
    input  wire logic [7:0] pulses_i,
    input  wire logic [3:0] half_i,
    output logic            busy_o,
    output logic            level_o
);
    logic [8:0] edges_reg = 9'h0;
    logic [3:0] hold_reg  = 4'h0;
    logic       level_reg = 1'b0;

    assign busy_o  = edges_reg != 9'h0;
    assign level_o = level_reg;

    // Each level stands half_i clocks, so the rate stays at or below half
    // the core clock; the line rests low between bursts.
    always @(posedge clock_i)
    begin
        if (start_i)
        begin
            edges_reg <= {pulses_i, 1'b0};
            hold_reg  <= 4'h0;
            level_reg <= 1'b0;
        end
        else if (busy_o && hold_reg >= half_i - 4'h1)
        begin
            edges_reg <= edges_reg - 9'h1;
            hold_reg  <= 4'h0;
            level_reg <= ~level_reg;
        end
        else if (busy_o)
            hold_reg <= hold_reg + 4'h1;
    end
endmodule : capture_edge_source

`default_nettype wire

/* verification/timer16_prescale_match_core_test.sv */
// Self-checking bench for the 16-bit timer core.
// Assumes the core, its checker and the edge source model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module timer16_prescale_match_core_test;
    typedef struct packed {logic [11:0] a; logic [31:0] wd; logic [31:0] rd;} row_s;
    typedef struct packed {logic [7:0] lim; logic [15:0] mv; logic [15:0] st;} run_s;
    typedef struct packed {logic [3:0] src; logic [3:0] half; logic [7:0] exp;} cnt_s;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        match_irq;
    logic        capture_level;
    logic        src_start = 1'b0;
    logic [3:0]  src_half = 4'h1;
    logic        src_busy;
    logic        err_seen;
    int          mismatches = 0;
    int          tests_run = 0;
    int          n;
    row_s rows [10] = '{'{12'h000, 32'hfffffffc, 32'h0}, '{12'h004, 32'hffffffff, 32'hffff},
        '{12'h008, 32'hffffffff, 32'hff}, '{12'h00c, 32'hffffffff, 32'hff},
        '{12'h010, 32'hffffffff, 32'hf}, '{12'h014, 32'hffffffff, 32'h7},
        '{12'h018, 32'hffffffff, 32'hffff}, '{12'h01c, 32'hffffffff, 32'h7},
        '{12'h020, 32'hffffffff, 32'h0}, '{12'hffc, 32'hffffffff, 32'h0}};
    run_s runs [4] = '{'{8'h00, 16'h0005, 16'h0000}, '{8'h00, 16'h0001, 16'hfffe},
        '{8'h02, 16'h0006, 16'h0000}, '{8'hff, 16'h0002, 16'h0000}};
    cnt_s cnts [4] = '{'{4'h1, 4'h1, 8'h05}, '{4'h2, 4'h3, 8'h05},
        '{4'h3, 4'h1, 8'h0a}, '{4'h7, 4'h2, 8'h00}};

    timer16_prescale_match_core DUT (
        .clock_i(clock), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .capture_input_zero_i(capture_level),
        .match_irq_o(match_irq));
    capture_edge_source src (.clock_i(clock), .start_i(src_start), .pulses_i(8'h05),
        .half_i(src_half), .busy_o(src_busy), .level_o(capture_level));

    initial
    begin
        forever #10 clock = ~clock;
    end

    // ==========
    // Tasks
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(what, exp, q);
    endtask : rd_chk

    task automatic wait_irq(inout int k);
        do
        begin
            @(posedge clock);
            #1;
            k++;
        end
        while (match_irq !== 1'b1);
    endtask : wait_irq

    task automatic run_match(input run_s r, input logic [2:0] act, input logic [2:0] cm,
                             output int k);
        wr(12'h000, 32'h0);
        wr(12'h008, {24'h0, r.lim});
        wr(12'h018, {16'h0, r.mv});
        wr(12'h014, {29'h0, act});
        wr(12'h01c, {29'h0, cm});
        wr(12'h000, 32'h2);
        wr(12'h004, {16'h0, r.st});
        wr(12'h000, 32'h1);
        k = 0;
        wait_irq(k);
    endtask : run_match

    function automatic logic [31:0] span(input run_s r);
        return (32'(r.lim) + 32'h1) * 32'(16'(r.mv - r.st)) + 32'h1;
    endfunction : span

    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    // ==========
    // Sequence
    initial
    begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        foreach (rows[i])
        begin
            rd_chk("reset value", rows[i].a, 32'h0);
            wr(rows[i].a, rows[i].wd);
            rd_chk("read back", rows[i].a, rows[i].rd);
            check("slave error", {31'h0, rows[i].a > 12'h01c}, {31'h0, err_seen});
            wr(rows[i].a, 32'h0);
        end
        $display("test registers done");
        foreach (runs[i])
        begin
            run_match(runs[i], 3'h1, 3'h0, n);
            check("cycles to match", span(runs[i]), n);
        end
        wr(12'h000, 32'h2);
        rd_chk("control", 12'h000, 32'h0);
        rd_chk("count", 12'h004, 32'h0);
        rd_chk("prescale count", 12'h00c, 32'h0);
        $display("test prescale done");
        run_match('{8'h00, 16'h0004, 16'h0000}, 3'h7, 3'h1, n);
        check("cycles to stop", 32'h5, n);
        rd_chk("control", 12'h000, 32'h0);
        rd_chk("count", 12'h004, 32'h4);
        #1;
        check("level irq", 32'h1, {31'h0, match_irq});
        $display("test stop done");
        run_match('{8'h01, 16'h0003, 16'h0000}, 3'h3, 3'h0, n);
        check("cycles to match", 32'h7, n);
        n = 0;
        wait_irq(n);
        check("match period", 32'h8, n);
        $display("test match reset done");
        // Match control is left in its cleared state throughout.
        foreach (cnts[i])
        begin
            wr(12'h014, 32'h0);
            wr(12'h008, 32'h0);
            wr(12'h010, {28'h0, cnts[i].src});
            wr(12'h000, 32'h2);
            wr(12'h000, 32'h1);
            @(posedge clock);
            src_half <= cnts[i].half;
            src_start <= 1'b1;
            @(posedge clock);
            src_start <= 1'b0;
            #1;
            while (src_busy)
            begin
                @(posedge clock);
                #1;
            end
            repeat (2) @(posedge clock);
            rd_chk("edge count", 12'h004, {24'h0, cnts[i].exp});
        end
        $display("test counter mode done");
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        conclude();
    end
endmodule : timer16_prescale_match_core_test

bind timer16_prescale_match_core timer16_core_checker chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .capture_input_zero_i(capture_input_zero_i), .match_irq_o(match_irq_o));

`default_nettype wire
